/* File: core/scl_pkg.sv */
// Package of constants for the stream configuration load port
package scl_pkg;

	// ****************************************
	// Mode select strap codes
	// ****************************************
	localparam logic [2:0] SCL_MODE_X32 = 3'h0;
	localparam logic [2:0] SCL_MODE_X16 = 3'h5;
	localparam logic [2:0] SCL_MODE_X8  = 3'h6;

	// ****************************************
	// Widths and counts
	// ****************************************
	localparam int SCL_DATA_W     = 32;
	localparam int SCL_SKID_DEPTH = 6;     // Words host may send after ready falls
	localparam int SCL_FIFO_DEPTH = 16;    // Link side buffer, holds skid words
	localparam int SCL_FIFO_AW    = 4;

	// ****************************************
	// Initialization phase timing
	// ****************************************
	localparam int SCL_CLK_MHZ    = 100;
	localparam int SCL_INIT_NS    = 1000;
	localparam int SCL_INIT_CYC   = (SCL_INIT_NS * SCL_CLK_MHZ) / 1000;
	localparam int SCL_INIT_CW    = 16;

	// ****************************************
	// Loader states
	// ****************************************
	typedef enum logic [4:0] {
		SCL_ST_CLEAR = 5'h01,
		SCL_ST_LOAD  = 5'h02,
		SCL_ST_INIT  = 5'h04,
		SCL_ST_USER  = 5'h08,
		SCL_ST_ERROR = 5'h10
	} scl_state_e;

endpackage

/* File: core/scl_skid_buf.sv */
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module scl_skid_buf #(
	parameter int WIDTH = 32
) (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             srst,
	// Filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);

	logic [WIDTH-1:0] mem_q [2];
	logic             wr_q;
	logic             rd_q;
	logic [1:0]       cnt_q;
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;

	// Honest flags from occupancy
	assign in_ready  = (cnt_q != 2'h2);
	assign out_valid = (cnt_q != 2'h0);
	assign out_data  = mem_q[rd_q];

	// Pointer and occupancy update
	always_ff @(posedge clock) begin
		if (srst) begin
			wr_q  <= 1'b0;
			rd_q  <= 1'b0;
			cnt_q <= 2'h0;
		end else begin
			if (push) begin
				mem_q[wr_q] <= in_data;
				wr_q        <= ~wr_q;
			end
			if (pop)
				rd_q <= ~rd_q;
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end

endmodule

/* File: core/scl_load_port.sv */
// Stream configuration load port: link capture, crossing and load control
`timescale 1ns/1ps
module scl_load_port
	import scl_pkg::*;
#(
	parameter int DATA_W    = SCL_DATA_W,
	parameter int INIT_CYC  = SCL_INIT_CYC
) (
	// Core clock and reset
	input  wire logic              clock,
	input  wire logic              srst,
	// Stream link, host clocked
	input  wire logic              cfg_stream_clock,
	input  wire logic [DATA_W-1:0] cfg_data,
	input  wire logic              cfg_valid,
	output logic                   cfg_ready,
	// Control pins
	input  wire logic              cfg_request_n,
	input  wire logic [2:0]        mode_select_straps,
	output logic                   status_n,
	output logic                   conf_done,
	output logic                   init_done,
	// Word output towards the configuration manager
	output logic [DATA_W-1:0]      load_data,
	output logic                   load_valid,
	input  wire logic              load_ready,
	input  wire logic              load_last
);

	// ****************************************
	// Link domain: capture buffer
	// ****************************************
	logic [DATA_W-1:0]      lk_mem [SCL_FIFO_DEPTH];
	logic [SCL_FIFO_AW:0]   lk_wr_bin_q;
	logic [SCL_FIFO_AW:0]   lk_wr_gray_q;
	logic [SCL_FIFO_AW:0]   lk_rd_gray_s1_q;
	logic [SCL_FIFO_AW:0]   lk_rd_gray_s2_q;
	logic                   lk_open_s1_q;
	logic                   lk_open_s2_q;
	logic                   lk_open_s3_q;
	logic                   lk_ready_q;
	logic [SCL_FIFO_AW:0]   lk_rd_bin;
	logic [SCL_FIFO_AW:0]   lk_used;
	wire                    lk_take;
	wire                    lk_room;
	logic                   load_open_q;    // Core side, read through three stages
	logic [SCL_FIFO_AW:0]   rd_gray_q;      // Core side, read through two stages

	// Gray to binary for the crossed read pointer
	function automatic logic [SCL_FIFO_AW:0] g2b(input logic [SCL_FIFO_AW:0] g);
		logic [SCL_FIFO_AW:0] b;
		b = '0;
		for (int i = SCL_FIFO_AW; i >= 0; i--)
			b[i] = (i == SCL_FIFO_AW) ? g[i] : (b[i+1] ^ g[i]);
		return b;
	endfunction

	assign lk_rd_bin = g2b(lk_rd_gray_s2_q);
	assign lk_used   = lk_wr_bin_q - lk_rd_bin;
	// Keep room for the words in flight after ready falls
	assign lk_room   = (lk_used < (SCL_FIFO_AW+1)'(SCL_FIFO_DEPTH - SCL_SKID_DEPTH - 1));
	// Only a cycle with valid and ready both high moves a word
	assign lk_take   = cfg_valid && lk_ready_q && (lk_used != (SCL_FIFO_AW+1)'(SCL_FIFO_DEPTH));

	// Load-open level crossing into the link domain
	always_ff @(posedge cfg_stream_clock) begin
		lk_open_s1_q <= load_open_q;
		lk_open_s2_q <= lk_open_s1_q;
		lk_open_s3_q <= lk_open_s2_q;
		lk_rd_gray_s1_q <= rd_gray_q;
		lk_rd_gray_s2_q <= lk_rd_gray_s1_q;
	end

	// Ready from buffer room while loading is open
	always_ff @(posedge cfg_stream_clock) begin
		lk_ready_q <= lk_open_s2_q && lk_open_s3_q && lk_room;
	end

	// Write side of the capture buffer
	always_ff @(posedge cfg_stream_clock) begin
		if (!(lk_open_s2_q && lk_open_s3_q)) begin
			lk_wr_bin_q  <= lk_rd_bin;
			lk_wr_gray_q <= lk_rd_gray_s2_q;
		end else if (lk_take) begin
			lk_mem[lk_wr_bin_q[SCL_FIFO_AW-1:0]] <= cfg_data;
			lk_wr_bin_q  <= lk_wr_bin_q + 1'b1;
			lk_wr_gray_q <= (lk_wr_bin_q + 1'b1) ^ ((lk_wr_bin_q + 1'b1) >> 1);
		end
	end

	assign cfg_ready = lk_ready_q;

	// ****************************************
	// Core domain: crossing and control
	// ****************************************
	logic [SCL_FIFO_AW:0] wr_gray_s1_q, wr_gray_s2_q;
	logic [SCL_FIFO_AW:0] rd_bin_q;
	logic [SCL_FIFO_AW:0] wr_bin_c;
	logic [2:0]           req_sync_q;
	logic [2:0]           mode_q;
	logic [2:0]           strap_s1_q, strap_s2_q, strap_s3_q;
	logic                 status_n_q, conf_done_q, init_done_q;
	logic [SCL_INIT_CW-1:0] init_cnt_q;
	scl_state_e           state_q, state_d;
	wire                  fifo_nonempty;
	wire                  fifo_pop;
	wire                  buf_in_ready;
	wire                  req_low;
	wire                  strap_steady;
	wire                  buf_drain;
	logic                 buf_out_valid;
	logic [DATA_W-1:0]    buf_out_data;
	logic                 load_valid_q;
	logic [DATA_W-1:0]    load_data_q;
	wire                  mode_ok;

	assign wr_bin_c      = g2b(wr_gray_s2_q);
	assign fifo_nonempty = (wr_bin_c != rd_bin_q) && load_open_q;
	assign fifo_pop      = fifo_nonempty && buf_in_ready;
	// Request pin: three stages, low once second and third both read low, released when either reads high
	assign req_low       = !req_sync_q[1] && !req_sync_q[2];
	assign strap_steady  = (strap_s2_q == strap_s3_q);
	// Buffer drains only when the output register takes its word
	assign buf_drain     = !load_valid_q || load_ready;
	assign mode_ok       = (mode_q == SCL_MODE_X32) || (mode_q == SCL_MODE_X16) ||
	                       (mode_q == SCL_MODE_X8);

	// Pin and pointer synchronisers
	always_ff @(posedge clock) begin
		wr_gray_s1_q <= lk_wr_gray_q;
		wr_gray_s2_q <= wr_gray_s1_q;
		req_sync_q   <= {req_sync_q[1:0], cfg_request_n};
		strap_s1_q   <= mode_select_straps;
		strap_s2_q   <= strap_s1_q;
		strap_s3_q   <= strap_s2_q;
	end

	// Read pointer of the capture buffer
	always_ff @(posedge clock) begin
		if (srst) begin
			rd_bin_q  <= '0;
			rd_gray_q <= '0;
		end else if (!load_open_q) begin
			rd_bin_q  <= wr_bin_c;
			rd_gray_q <= wr_gray_s2_q;
		end else if (fifo_pop) begin
			rd_bin_q  <= rd_bin_q + 1'b1;
			rd_gray_q <= (rd_bin_q + 1'b1) ^ ((rd_bin_q + 1'b1) >> 1);
		end
	end

	// Two-entry buffer towards the manager
	scl_skid_buf #(
		.WIDTH     (DATA_W)
	) u_buf (
		.clock     (clock),
		.srst      (srst || !load_open_q),
		.in_valid  (fifo_nonempty),
		.in_ready  (buf_in_ready),
		.in_data   (lk_mem[rd_bin_q[SCL_FIFO_AW-1:0]]),
		.out_valid (buf_out_valid),
		.out_ready (buf_drain),
		.out_data  (buf_out_data)
	);

	// State machine: clear, load, init, user, error
	always_comb begin
		state_d = state_q;
		case (state_q)
			SCL_ST_CLEAR: if (!req_low) state_d = mode_ok ? SCL_ST_LOAD : SCL_ST_ERROR;
			SCL_ST_LOAD:  if (load_last && load_ready && load_valid_q) state_d = SCL_ST_INIT;
			SCL_ST_INIT:  if (init_cnt_q == SCL_INIT_CW'(INIT_CYC - 1)) state_d = SCL_ST_USER;
			SCL_ST_USER:  state_d = state_q;
			SCL_ST_ERROR: state_d = state_q;
			default:      state_d = SCL_ST_CLEAR;
		endcase
		if (req_low)
			state_d = SCL_ST_CLEAR;
	end

	// State, straps and pin outputs
	always_ff @(posedge clock) begin
		if (srst) begin
			state_q     <= SCL_ST_CLEAR;
			mode_q      <= SCL_MODE_X32;
			load_open_q <= 1'b0;
			status_n_q  <= 1'b0;
			conf_done_q <= 1'b0;
			init_done_q <= 1'b0;
			init_cnt_q  <= '0;
		end else begin
			state_q     <= state_d;
			if ((state_q == SCL_ST_CLEAR) && strap_steady)
				mode_q <= strap_s3_q;     // Straps read only while clearing
			load_open_q <= (state_d == SCL_ST_LOAD);
			// Ready only counts while status is high
			status_n_q  <= (state_d != SCL_ST_CLEAR) && (state_d != SCL_ST_ERROR);
			conf_done_q <= (state_d == SCL_ST_INIT) || (state_d == SCL_ST_USER);
			init_done_q <= (state_d == SCL_ST_USER);
			// Init counts core clock, not the stream clock
			init_cnt_q  <= (state_q == SCL_ST_INIT) ? init_cnt_q + 1'b1 : '0;
		end
	end

	// Output register towards the manager, width follows mode
	always_ff @(posedge clock) begin
		if (srst || !load_open_q) begin
			load_valid_q <= 1'b0;
			load_data_q  <= '0;
		end else if (buf_drain) begin
			load_valid_q <= buf_out_valid;
			load_data_q  <= (mode_q == SCL_MODE_X8)  ? DATA_W'(buf_out_data[7:0]) :
			                (mode_q == SCL_MODE_X16) ? DATA_W'(buf_out_data[15:0]) :
			                buf_out_data;
		end
	end
	assign load_valid = load_valid_q;
	assign load_data  = load_data_q;
	assign status_n   = status_n_q;
	assign conf_done  = conf_done_q;
	assign init_done  = init_done_q;

endmodule

/* File: bench/scl_load_port_monitor.sv */
// Checker of the stream configuration load port
`timescale 1ns/1ps
module scl_load_port_monitor
	import scl_pkg::*;
#(
	parameter int INIT_CYC = 4
) (
	// Clocks and reset
	input wire logic        clock,
	input wire logic        srst,
	input wire logic        cfg_stream_clock,
	// Observed pins
	input wire logic        cfg_ready,
	input wire logic [2:0]  mode_select_straps,
	input wire logic        status_n,
	input wire logic        conf_done,
	input wire logic        init_done,
	input wire logic [31:0] load_data,
	input wire logic        load_valid,
	input wire logic        load_ready
);
	logic [15:0] init_cnt_q;

	// Cycles spent initializing
	always_ff @(posedge clock)
		if (srst || !conf_done) init_cnt_q <= 16'h0;
		else if (!init_done) init_cnt_q <= init_cnt_q + 16'h1;

	// Word offered but not taken
	sequence s_stall;
		load_valid && !load_ready;
	endsequence
	sequence s_held;
		load_valid && $stable(load_data);
	endsequence

	AST_RST_IDLE: assert property (
		@(posedge clock) srst |=> !status_n && !conf_done && !init_done && !load_valid
	) else $error("outputs active after reset");
	AST_WORD_HELD: assert property (
		@(posedge clock) disable iff (srst) s_stall |=> s_held
	) else $error("load word dropped");
	AST_INIT_TIME: assert property (
		@(posedge clock) disable iff (srst)
		$rose(init_done) |-> init_cnt_q == 16'(INIT_CYC)
	) else $error("init length wrong");
	AST_INIT_AFTER_DONE: assert property (
		@(posedge clock) disable iff (srst) init_done |-> conf_done
	) else $error("init without done");
	AST_DONE_STATUS: assert property (
		@(posedge clock) disable iff (srst) conf_done |-> status_n
	) else $error("done with status low");
	AST_READY_RISE: assert property (
		@(posedge cfg_stream_clock) disable iff (srst) $rose(cfg_ready) |-> status_n && !conf_done
	) else $error("ready outside loading");
	AST_X8_ZERO: assert property (
		@(posedge clock) disable iff (srst)
		load_valid && mode_select_straps == SCL_MODE_X8 |-> load_data[31:8] == 24'h0
	) else $error("narrow word not extended");
	AST_X16_ZERO: assert property (
		@(posedge clock) disable iff (srst)
		load_valid && mode_select_straps == SCL_MODE_X16 |-> load_data[31:16] == 16'h0
	) else $error("half word not extended");
endmodule

bind scl_load_port scl_load_port_monitor #(
	.INIT_CYC           (INIT_CYC)
) u_scl_load_port_monitor (
	.clock              (clock),
	.srst               (srst),
	.cfg_stream_clock   (cfg_stream_clock),
	.cfg_ready          (cfg_ready),
	.mode_select_straps (mode_select_straps),
	.status_n           (status_n),
	.conf_done          (conf_done),
	.init_done          (init_done),
	.load_data          (load_data),
	.load_valid         (load_valid),
	.load_ready         (load_ready)
);

/* File: bench/scl_host_model.sv */
// Host model driving the configuration stream
`timescale 1ns/1ps
module scl_host_model (
	// Pacing from the bench
	input wire logic [7:0]  limit,
	input wire logic        slow,
	// Device pins
	input wire logic        status_n,
	input wire logic        conf_done,
	input wire logic        cfg_ready,
	output logic            cfg_stream_clock,
	output logic            cfg_valid,
	output logic [31:0]     cfg_data
);
	logic [1:0] rdy_s = 2'h0;
	logic [7:0] sent;
	logic       pace = 1'b0;
	logic       go;

	// Stream clock runs until complete, then stands low
	initial begin
		cfg_stream_clock = 1'b0;
		cfg_valid = 1'b0;
		cfg_data = 32'h0;
		#2.3;
		forever #15 cfg_stream_clock = !conf_done ? ~cfg_stream_clock : 1'b0;
	end

	// Offer only on synced ready with status high
	assign go = rdy_s[1] && status_n && pace && sent < limit;

	// Word source, holds a word until taken
	always @(posedge cfg_stream_clock) begin
		rdy_s <= {rdy_s[0], cfg_ready};
		pace <= slow ? ~pace : 1'b1;
		if (!status_n) begin
			sent <= 8'h0;
			cfg_valid <= 1'b0;
		end else if (!cfg_valid || cfg_ready) begin
			cfg_valid <= go;
			cfg_data <= go ? {sent ^ 8'hc3, 8'h5a, sent, sent ^ 8'ha5} : ~cfg_data;
			sent <= sent + {7'h0, go};
		end
	end
endmodule

/* File: bench/scl_load_port_tb.sv */
// Testbench of the stream configuration load port
`timescale 1ns/1ps
module scl_load_port_tb;
	import scl_pkg::*;
	localparam int INIT_N = 4;
	logic        clock = 1'b0;
	logic        srst = 1'b1;
	logic        cfg_request_n = 1'b1;
	logic [2:0]  mode_select_straps = SCL_MODE_X32;
	logic        load_ready = 1'b0;
	logic        load_last = 1'b0;
	logic [7:0]  limit = 8'h0;
	logic        slow = 1'b0;
	logic        cfg_stream_clock, cfg_valid, cfg_ready, status_n;
	logic        conf_done, init_done, load_valid;
	logic [31:0] cfg_data, load_data;
	int          num_errors = 0;
	int          check_count = 0;

	// Core clock
	always #5 clock = ~clock;

	scl_load_port #(
		.INIT_CYC           (INIT_N)
	) u_scl_load_port (
		.clock              (clock),
		.srst               (srst),
		.cfg_stream_clock   (cfg_stream_clock),
		.cfg_data           (cfg_data),
		.cfg_valid          (cfg_valid),
		.cfg_ready          (cfg_ready),
		.cfg_request_n      (cfg_request_n),
		.mode_select_straps (mode_select_straps),
		.status_n           (status_n),
		.conf_done          (conf_done),
		.init_done          (init_done),
		.load_data          (load_data),
		.load_valid         (load_valid),
		.load_ready         (load_ready),
		.load_last          (load_last)
	);

	scl_host_model u_scl_host_model (
		.limit              (limit),
		.slow               (slow),
		.status_n           (status_n),
		.conf_done          (conf_done),
		.cfg_ready          (cfg_ready),
		.cfg_stream_clock   (cfg_stream_clock),
		.cfg_valid          (cfg_valid),
		.cfg_data           (cfg_data)
	);

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// Clearing pulse, straps, then word budget
	task automatic request_pulse(input logic [2:0] m, input logic [7:0] n);
		@(posedge clock);
		mode_select_straps <= m;
		cfg_request_n <= 1'b0;
		repeat (6) @(posedge clock);
		cfg_request_n <= 1'b1;
		limit <= n;
	endtask

	// Full load with long stall, drain and completion
	task automatic load_run(input logic [2:0] m, input logic [31:0] mask, input logic st);
		int i;
		int t;
		logic [7:0] n;
		i = 0;
		slow <= st;
		request_pulse(m, 8'd24);
		for (t = 0; t < 3000 && i < 24; t++) begin
			@(posedge clock);
			if (t == 150) check("ready in stall", {31'h0, cfg_ready}, 32'h0);
			if (load_valid && load_ready) begin
				n = i[7:0];
				check("word", load_data, {n ^ 8'hc3, 8'h5a, n, n ^ 8'ha5} & mask);
				i++;
			end
			load_ready <= i < 24 && t >= 160 && (!st || t[1]);
			load_last <= i == 23;
		end
		check("words", i, 32'd24);
		if (i != 24) stop_test();
		for (t = 0; t < 50 && !conf_done; t++) @(posedge clock);
		check("done", {31'h0, conf_done}, 32'h1);
		if (!conf_done) stop_test();
		for (t = 0; t < 50 && !init_done; t++) @(posedge clock);
		check("init time", {31'h0, t >= INIT_N - 1 && t <= INIT_N + 2}, 32'h1);
		if (!init_done) stop_test();
	endtask

	// Unknown strap code keeps the port refusing
	task automatic bad_strap();
		int t;
		request_pulse(3'h3, 8'd4);
		repeat (30) @(posedge clock);
		for (t = 0; t < 60; t++) begin
			@(posedge clock);
			if (status_n !== 1'b0 || cfg_ready !== 1'b0 || load_valid !== 1'b0) break;
		end
		check("strap error held", t, 32'd60);
	endtask

	// Main sequence
	initial begin
		repeat (16) @(posedge clock);
		check("reset outs", {28'h0, status_n, conf_done, init_done, load_valid}, 32'h0);
		srst <= 1'b0;
		load_run(SCL_MODE_X32, 32'hffffffff, 1'b1);
		load_run(SCL_MODE_X16, 32'h0000ffff, 1'b0);
		load_run(SCL_MODE_X8, 32'h000000ff, 1'b1);
		bad_strap();
		stop_test();
	end
endmodule
